// ### fsr_core.sv
// suspend/resume and identification-read sequencer of a serial flash
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_core
	import fsr_pkg::*;
#(
	parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] TYPE_CODE = 8'h3C, // arbitrary value
	parameter logic [7:0] CAP_CODE = 8'h0F, // arbitrary value
	parameter int PROG_CYCLES = `FSR_PROG_TIME_NS / `FSR_CLK_NS,
	parameter int ERASE_CYCLES = `FSR_ERASE_TIME_NS / `FSR_CLK_NS,
	parameter int SUS_CYCLES = (`FSR_SUS_LAT_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	// array region guard and flags
	input wire logic addr_in_busy_region_i,
	output logic array_read_ok_o,
	output logic [15:0] status_o,
	output logic cmd_accept_o,
	output logic [7:0] cmd_code_o
);
	// ----------------------------------------------------------------
	// link sampling
	// ----------------------------------------------------------------
	logic cs_n;
	logic si;
	logic rise;
	logic fall;
	fsr_link_rx u_rx (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.si_i(si_i),
		.cs_n_o(cs_n),
		.si_o(si),
		.rise_o(rise),
		.fall_o(fall)
	);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		fsr_phase_t phase;
		logic [7:0] shreg;
		logic [2:0] bitcnt;
		logic [7:0] cmd;
		logic [23:0] id_sh;
		logic [4:0] id_left;
		logic so;
		logic so_oe;
		logic write_enable_latch;
		logic write_in_progress;
		logic suspended_flag;
		fsr_op_t op;
		fsr_op_t nested;
		logic [31:0] work;
		logic [31:0] nwork;
		logic [15:0] lat;
		logic accept;
		logic [7:0] acc_code;
		logic rst_arm;
	} fsr_state_t;
	fsr_state_t r;
	fsr_state_t n;
	// ----------------------------------------------------------------
	// command gating while suspended
	// ----------------------------------------------------------------
	function automatic logic anytime_cmd(input logic [7:0] c);
		case (c)
			`FSR_OP_WRITE_DISABLE_CMD, `FSR_OP_SR_LOW, `FSR_OP_SR_HIGH, `FSR_OP_SIG,
			`FSR_OP_RST_ARM, `FSR_OP_RST, `FSR_OP_NOP: anytime_cmd = 1'b1;
			default: anytime_cmd = 1'b0;
		endcase
	endfunction
	function automatic logic gated_cmd(input logic [7:0] c, input fsr_op_t t);
		case (c)
			`FSR_OP_READ, `FSR_OP_FAST_READ, `FSR_OP_QUAD_IO_READ, `FSR_OP_PARAM,
			`FSR_OP_ID_READ, `FSR_OP_RESUME: gated_cmd = 1'b1;
			`FSR_OP_WRITE_ENABLE_CMD, `FSR_OP_PP, `FSR_OP_QPP: gated_cmd = (t == FSR_OP_ERASE);
			default: gated_cmd = 1'b0;
		endcase
	endfunction
	// busy means a cycle runs: a main one not suspended, or a nested program
	// the suspend latency counts as busy, the array is not yet free then
	logic busy;
	assign busy = (r.op != FSR_OP_NONE && !r.suspended_flag) || r.nested != FSR_OP_NONE;
	// decode is allowed at byte completion; whether the command is legal now
	function automatic logic legal(input fsr_state_t s, input logic [7:0] c, input logic b);
		if (s.suspended_flag || s.lat != 16'h0) begin
			if (s.nested != FSR_OP_NONE) begin
				legal = anytime_cmd(c);
			end else begin
				legal = anytime_cmd(c) || (s.suspended_flag && gated_cmd(c, s.op));
			end
		end else if (b) begin
			legal = anytime_cmd(c) || c == `FSR_OP_WRITE_ENABLE_CMD;
		end else begin
			legal = 1'b1;
		end
	endfunction
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] byte_in;
		logic ok;
		n = r;
		byte_in = {r.shreg[6:0], si};
		ok = 1'b0;
		n.accept = 1'b0;
		// internal timers
		if (r.lat != 16'h0) begin
			n.lat = r.lat - 16'h1;
			if (r.lat == 16'h1) begin
				n.write_enable_latch = 1'b0;
				n.suspended_flag = 1'b1;
			end
		end else if (r.nested != FSR_OP_NONE) begin
			if (r.nwork == 32'h0) begin
				n.nested = FSR_OP_NONE;
				n.write_enable_latch = 1'b0;
				n.write_in_progress = 1'b0;
			end else begin
				n.nwork = r.nwork - 32'h1;
			end
		end else if (r.op != FSR_OP_NONE && !r.suspended_flag) begin
			if (r.work == 32'h0) begin
				n.op = FSR_OP_NONE;
				n.write_enable_latch = 1'b0;
				n.write_in_progress = 1'b0;
			end else begin
				n.work = r.work - 32'h1;
			end
		end
		// serial side
		if (cs_n) begin
			n.phase = FSR_PH_CMD;
			n.bitcnt = 3'h0;
			n.so_oe = 1'b0;
			n.id_left = 5'h0;
		end else begin
			if (rise && r.phase == FSR_PH_CMD) begin
				n.shreg = byte_in;
				n.bitcnt = r.bitcnt + 3'h1;
				if (r.bitcnt == 3'h7) begin
					ok = legal(r, byte_in, busy);
					n.phase = FSR_PH_SKIP;
					if (ok) begin
						n.cmd = byte_in;
						n.accept = 1'b1;
						n.acc_code = byte_in;
						// any accepted command but the suspend of a running cycle between arming and reset disarms it
						if (byte_in != `FSR_OP_RST) begin
							n.rst_arm = (byte_in == `FSR_OP_RST_ARM);
						end
						case (byte_in)
							`FSR_OP_ID_READ: begin
								n.phase = FSR_PH_ID;
								n.id_sh = {MFR_CODE, TYPE_CODE, CAP_CODE};
								n.id_left = 5'd24;
							end
							`FSR_OP_WRITE_ENABLE_CMD: n.write_enable_latch = 1'b1;
							`FSR_OP_WRITE_DISABLE_CMD: if (r.nested == FSR_OP_NONE) n.write_enable_latch = 1'b0;
							`FSR_OP_RESUME: begin
								if (r.suspended_flag && r.nested == FSR_OP_NONE) begin
									n.suspended_flag = 1'b0;
									n.write_enable_latch = 1'b1;
									n.write_in_progress = 1'b1;
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
			if (fall && r.phase == FSR_PH_ID) begin
				if (r.id_left != 5'h0) begin
					n.so = r.id_sh[23];
					n.so_oe = 1'b1;
					n.id_sh = {r.id_sh[22:0], 1'b0};
					n.id_left = r.id_left - 5'h1;
				end else begin
					n.so_oe = 1'b0;
				end
			end
		end
		// program, erase and reset commands acting on the cycle take effect at chip select rise
		if (cs_n && r.phase == FSR_PH_SKIP && r.bitcnt == 3'h0) begin
			case (r.cmd)
				`FSR_OP_PP, `FSR_OP_QPP: begin
					if (r.write_enable_latch && !r.suspended_flag && r.op == FSR_OP_NONE) begin
						n.op = FSR_OP_PROG;
						n.work = 32'(PROG_CYCLES);
						n.write_in_progress = 1'b1;
					end else if (r.write_enable_latch && r.suspended_flag && r.op == FSR_OP_ERASE
						&& !addr_in_busy_region_i && r.nested == FSR_OP_NONE) begin
						n.nested = FSR_OP_PROG;
						n.nwork = 32'(PROG_CYCLES);
						n.write_in_progress = 1'b1;
					end
				end
				`FSR_OP_SE, `FSR_OP_BE32, `FSR_OP_BE64, `FSR_OP_PE: begin
					if (r.write_enable_latch && !r.suspended_flag && r.op == FSR_OP_NONE) begin
						n.op = FSR_OP_ERASE;
						n.work = 32'(ERASE_CYCLES);
						n.write_in_progress = 1'b1;
					end
				end
				`FSR_OP_RST: begin
					// a lone reset byte must not wipe a running cycle
					if (r.rst_arm) begin
						n.op = FSR_OP_NONE;
						n.nested = FSR_OP_NONE;
						n.suspended_flag = 1'b0;
						n.write_enable_latch = 1'b0;
						n.write_in_progress = 1'b0;
						n.lat = 16'h0;
					end
					n.rst_arm = 1'b0;
				end
				default: begin
				end
			endcase
			n.cmd = `FSR_OP_NOP;
		end
		// suspend: only a running main cycle, never a nested program
		if (!cs_n && rise && r.phase == FSR_PH_CMD && r.bitcnt == 3'h7
			&& byte_in == `FSR_OP_SUS_CODE && r.op != FSR_OP_NONE && !r.suspended_flag
			&& r.lat == 16'h0 && r.nested == FSR_OP_NONE) begin
			n.lat = 16'(SUS_CYCLES);
			n.accept = 1'b1;
			n.acc_code = byte_in;
		end
	end
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{phase: FSR_PH_CMD, op: FSR_OP_NONE, nested: FSR_OP_NONE, default: '0};
		end else begin
			r <= n;
		end
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		status_o = 16'h0;
		status_o[`FSR_SR_WIP_BIT] = r.write_in_progress;
		status_o[`FSR_SR_WEL_BIT] = r.write_enable_latch;
		status_o[`FSR_SR_SUS_BIT] = r.suspended_flag;
	end
	// reads must avoid the suspended region
	assign array_read_ok_o = !busy && !(r.suspended_flag && addr_in_busy_region_i);
	assign so_o = r.so;
	assign so_oe_o = r.so_oe;
	assign cmd_accept_o = r.accept;
	assign cmd_code_o = r.acc_code;
endmodule

// ### fsr_map.svh
// constants of the suspend/resume and identification-read sequencer
// ----------------------------------------------------------------
// Summary of operation
// - ID read returns three bytes, 24 bits
// - chip select high ends ID output anytime
// - no ID decode while program/erase runs
// - standby once chip select rises after ID
// - suspend interrupts program or any erase
// - suspended region not readable, rest readable
// - after latency clear enable latch, set suspended
// - reads, ID, parameter, resume accepted after latency
// - erase suspend allows enable and page program
// - disable, status, signature, reset accepted anytime
// - status bit 15 shows suspended state
// - program inside erase suspend not suspendable
// - nested program holds latch and busy high
// - programming refused during program suspend
// - resume sets latch and busy, clears suspended
// - resumed operation continues until done
// ----------------------------------------------------------------
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_OP_READ 8'h03
`define FSR_OP_FAST_READ 8'h0B
`define FSR_OP_QUAD_IO_READ 8'hEB
`define FSR_OP_PARAM 8'hC0
`define FSR_OP_ID_READ 8'h9F
`define FSR_OP_WRITE_ENABLE_CMD 8'h06
`define FSR_OP_WRITE_DISABLE_CMD 8'h04
`define FSR_OP_PP 8'h02
`define FSR_OP_QPP 8'h32
`define FSR_OP_SR_LOW 8'h05
`define FSR_OP_SR_HIGH 8'h35
`define FSR_OP_SIG 8'hAB
`define FSR_OP_RST_ARM 8'h66
`define FSR_OP_RST 8'h99
`define FSR_OP_NOP 8'h00
`define FSR_OP_RESUME 8'h7A
`define FSR_OP_SE 8'h20
`define FSR_OP_BE32 8'h52
`define FSR_OP_BE64 8'hD8
`define FSR_OP_PE 8'h81
`define FSR_OP_SUS_CODE 8'h75
`define FSR_SR_WIP_BIT 0
`define FSR_SR_WEL_BIT 1
`define FSR_SR_SUS_BIT 15
`define FSR_PROG_TIME_NS 20000
`define FSR_ERASE_TIME_NS 400000
`define FSR_SUS_LAT_NS 200
`define FSR_CLK_NS 10
`endif

// ### fsr_pkg.sv
// types of the suspend/resume and identification-read sequencer
package fsr_pkg;
	typedef enum logic [1:0] {FSR_OP_NONE, FSR_OP_PROG, FSR_OP_ERASE} fsr_op_t;
	typedef enum logic [1:0] {FSR_PH_CMD, FSR_PH_ARG, FSR_PH_ID, FSR_PH_SKIP} fsr_phase_t;
endpackage

// ### fsr_link_rx.sv
// link front end: synchronisers and serial clock edge finder
`timescale 1ns/10ps
module fsr_link_rx (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// link pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	// synchronised view
	output logic cs_n_o,
	output logic si_o,
	output logic rise_o,
	output logic fall_o
);
	logic [1:0] s_clk;
	logic [1:0] s_cs;
	logic [1:0] s_si;
	logic clk_d;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_clk <= 2'h0;
			s_cs <= 2'h3;
			s_si <= 2'h0;
			clk_d <= 1'b0;
		end else begin
			s_clk <= {s_clk[0], sclk_i};
			s_cs <= {s_cs[0], cs_n_i};
			s_si <= {s_si[0], si_i};
			clk_d <= s_clk[1];
		end
	end
	assign cs_n_o = s_cs[1];
	assign si_o = s_si[1];
	assign rise_o = s_clk[1] & ~clk_d;
	assign fall_o = ~s_clk[1] & clk_d;
endmodule

// ### fsr_core_chk.sv
// port assertions of the sequencer
`timescale 1ns/10ps
module fsr_core_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// watched ports
	input wire logic cs_n_i,
	input wire logic so_oe_o,
	input wire logic addr_in_busy_region_i,
	input wire logic array_read_ok_o,
	input wire logic [15:0] status_o,
	input wire logic cmd_accept_o,
	input wire logic [7:0] cmd_code_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence s_sus_set;
		$rose(status_o[15]);
	endsequence
	sequence s_resumed;
		$fell(status_o[15]);
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	accept_pulse_a: assert property (cmd_accept_o |=> !cmd_accept_o)
		else $error("accept pulse longer than one cycle");
	sus_latch_a: assert property (s_sus_set |-> !status_o[1])
		else $error("suspended with latch still set");
	resume_flags_a: assert property (s_resumed |-> status_o[0] && status_o[1])
		else $error("resume without latch and busy");
	sus_region_a: assert property (status_o[15] && addr_in_busy_region_i |-> !array_read_ok_o)
		else $error("suspended region readable");
	busy_read_a: assert property (status_o[0] && !status_o[15] |-> !array_read_ok_o)
		else $error("array read while cycle runs");
	busy_id_a: assert property (cmd_accept_o && status_o[0] && !status_o[15] |-> cmd_code_o != 8'h9F)
		else $error("id read decoded while busy");
	done_clear_a: assert property ($fell(status_o[0]) |-> !status_o[1])
		else $error("latch left set at completion");
	oe_cs_a: assert property (so_oe_o |-> !$past(cs_n_i, 5))
		else $error("output driven after deselect");
	oe_id_a: assert property ($rose(so_oe_o) |-> cmd_code_o == 8'h9F)
		else $error("output enabled without id read");
endmodule
bind fsr_core fsr_core_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
	.so_oe_o(so_oe_o), .addr_in_busy_region_i(addr_in_busy_region_i),
	.array_read_ok_o(array_read_ok_o), .status_o(status_o), .cmd_accept_o(cmd_accept_o),
	.cmd_code_o(cmd_code_o));

// ### fsr_host_model.sv
// host serial controller model driving the link
`timescale 1ns/10ps
module fsr_host_model (
	// clock
	input wire logic clk_sys_i,
	// link pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i,
	input wire logic cmd_accept_i
);
	int acc_cnt = 0;
	initial begin
		sclk_o = 0;
		cs_n_o = 1;
		si_o = 0;
	end
	always @(posedge clk_sys_i) begin
		if (cmd_accept_i) acc_cnt <= acc_cnt + 1;
	end
	// half of a 160 ns serial clock period
	task half;
		repeat (8) @(negedge clk_sys_i);
	endtask
	task xfer(input logic [31:0] tx, input int ntx, input int nrx,
		output logic [23:0] rx, output logic acc, output logic oe);
		int a0;
		a0 = acc_cnt;
		rx = 0;
		oe = 0;
		@(negedge clk_sys_i);
		cs_n_o = 0;
		for (int i = 0; i < ntx; i++) begin
			si_o = tx[31-i];
			half;
			sclk_o = 1;
			half;
			sclk_o = 0;
		end
		// a bit is taken before the rise; it stands until the next fall
		for (int i = 0; i < nrx; i++) begin
			half;
			// an undriven line has no pull, so it is taken as the inverse
			rx = {rx[22:0], so_oe_i ? so_i : ~so_i};
			oe = oe | so_oe_i;
			sclk_o = 1;
			half;
			sclk_o = 0;
		end
		half;
		cs_n_o = 1;
		si_o = ~si_o;
		half;
		half;
		acc = (acc_cnt != a0);
	endtask
endmodule

// ### fsr_core_tb.sv
// self-checking bench of the sequencer
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_core_tb;
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic busy_reg = 0;
	logic sclk, cs_n, si, so, so_oe, rd_ok, acc, ok, oe;
	logic [15:0] status;
	logic [7:0] code;
	logic [23:0] rx;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	localparam int PROG_N = `FSR_PROG_TIME_NS / `FSR_CLK_NS;
	always #5 clk_sys_i = ~clk_sys_i;
	fsr_host_model host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
		.so_i(so), .so_oe_i(so_oe), .cmd_accept_i(acc));
	fsr_core #(.MFR_CODE(8'h5A), .TYPE_CODE(8'hC3), .CAP_CODE(8'h21),
		.ERASE_CYCLES(3000), .SUS_CYCLES(400)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
		.addr_in_busy_region_i(busy_reg), .array_read_ok_o(rd_ok), .status_o(status),
		.cmd_accept_o(acc), .cmd_code_o(code));
	task stop_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ceiling well above the roughly 13000 cycles the tests need
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			stop_test;
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wait_sts(input int b, input logic v, input int n);
		for (int i = 0; i < n && status[b] !== v; i++) @(negedge clk_sys_i);
		chk({23'h0, status[b]}, {23'h0, v});
	endtask
	task cmd(input logic [7:0] op);
		host.xfer({op, 24'h0}, 8, 0, rx, ok, oe);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_id;
		host.xfer({8'h9F, 24'h0}, 8, 24, rx, ok, oe);
		chk(rx, 24'h5AC321);
		chk({16'h0, code}, {16'h0, `FSR_OP_ID_READ});
		chk({23'h0, so_oe}, 24'h0);
		host.xfer({8'h9F, 24'h0}, 8, 10, rx, ok, oe);
		chk(rx, 24'h00016B);
		chk({23'h0, so_oe}, 24'h0);
		$display("test id read done");
	endtask
	task t_idle_sus;
		cmd(`FSR_OP_SUS_CODE);
		repeat (450) @(negedge clk_sys_i);
		chk({23'h0, status[15]}, 24'h0);
		$display("test idle suspend done");
	endtask
	task t_erase;
		cmd(`FSR_OP_WRITE_ENABLE_CMD);
		host.xfer({`FSR_OP_SE, 24'h001000}, 32, 0, rx, ok, oe);
		wait_sts(0, 1, 50);
		host.xfer({8'h9F, 24'h0}, 8, 24, rx, ok, oe);
		chk({23'h0, oe}, 24'h0);
		cmd(`FSR_OP_SUS_CODE);
		cmd(`FSR_OP_SR_LOW);
		chk({23'h0, ok}, 24'h1);
		cmd(`FSR_OP_READ);
		chk({23'h0, ok}, 24'h0);
		wait_sts(15, 1, 500);
		chk({23'h0, status[1]}, 24'h0);
		busy_reg = 1;
		@(negedge clk_sys_i);
		chk({23'h0, rd_ok}, 24'h0);
		busy_reg = 0;
		@(negedge clk_sys_i);
		chk({23'h0, rd_ok}, 24'h1);
		cmd(`FSR_OP_READ);
		chk({23'h0, ok}, 24'h1);
		cmd(`FSR_OP_SE);
		chk({23'h0, ok}, 24'h0);
		cmd(`FSR_OP_WRITE_ENABLE_CMD);
		wait_sts(1, 1, 20);
		host.xfer({`FSR_OP_PP, 24'h002000}, 32, 0, rx, ok, oe);
		chk({23'h0, ok}, 24'h1);
		chk(status[1:0], 24'h3);
		wait_sts(0, 0, PROG_N + 100);
		chk({23'h0, status[1]}, 24'h0);
		cmd(`FSR_OP_RESUME);
		chk({status[15], status[1:0]}, 24'h3);
		wait_sts(0, 0, 4000);
		$display("test erase suspend done");
	endtask
	task t_prog;
		cmd(`FSR_OP_WRITE_ENABLE_CMD);
		host.xfer({`FSR_OP_PP, 24'h003000}, 32, 0, rx, ok, oe);
		cmd(`FSR_OP_SUS_CODE);
		wait_sts(15, 1, 600);
		cmd(`FSR_OP_WRITE_ENABLE_CMD);
		chk({ok, status[1]}, 24'h0);
		host.xfer({`FSR_OP_PP, 24'h004000}, 32, 0, rx, ok, oe);
		chk({23'h0, ok}, 24'h0);
		cmd(`FSR_OP_RESUME);
		wait_sts(15, 0, 20);
		wait_sts(0, 0, PROG_N + 100);
		cmd(`FSR_OP_WRITE_ENABLE_CMD);
		cmd(`FSR_OP_RST);
		chk({23'h0, status[1]}, 24'h1);
		cmd(`FSR_OP_RST_ARM);
		cmd(`FSR_OP_RST);
		chk({23'h0, status[1]}, 24'h0);
		$display("test program suspend done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 0;
		repeat (4) @(negedge clk_sys_i);
		t_id;
		t_idle_sus;
		t_erase;
		t_prog;
		stop_test;
	end
endmodule
